//--- design/kmi_consts.vh
// Constants for the key matrix line interrupt block
`ifndef KMI_CONSTS_VH
`define KMI_CONSTS_VH

// Register indices as printed; byte address is four times the index
`define KMI_IDX_LEVEL      8'h9C
`define KMI_IDX_ENABLE     8'h9D
`define KMI_IDX_FLAGS      8'h9E
`define KMI_IDX_CTRL       8'hA0
`define KMI_ADDR_LEVEL     12'h270
`define KMI_ADDR_ENABLE    12'h274
`define KMI_ADDR_FLAGS     12'h278
`define KMI_ADDR_CTRL      12'h280

// Field position and line count
`define KMI_CTRL_GLOBAL_EN 0
`define KMI_LINES          8

// Reset values
`define KMI_RST_ENABLE     8'h00
`define KMI_RST_FLAGS      8'h00
`define KMI_RST_LEVEL      8'h00
`define KMI_RST_CTRL       1'b0

// AXI responses
`define KMI_RESP_OKAY      2'h0
`define KMI_RESP_SLVERR    2'h2

`endif

//--- design/kmi_line_sync.v
// Two-stage synchroniser and level match for the eight port lines
`timescale 1ns/1ps
`include "kmi_consts.vh"

module kmi_line_sync (
    input  wire                   clock,
    input  wire                   reset_n,
    input  wire [`KMI_LINES-1:0]  port_one,
    input  wire [`KMI_LINES-1:0]  key_level_select,
    output wire [`KMI_LINES-1:0]  line_match
);

    genvar i;
    generate
        for (i = 0; i < `KMI_LINES; i = i + 1) begin : g_line
            reg meta_reg;
            reg sync_reg;
            always @(posedge clock) begin
                if (!reset_n) begin
                    // Reset to the pulled-up idle level, else release
                    // would fake a low-level match on every line
                    meta_reg <= 1'b1;
                    sync_reg <= 1'b1;
                end else begin
                    meta_reg <= port_one[i];
                    sync_reg <= meta_reg;
                end
            end
            // Low level when select is zero, high level when one
            assign line_match[i] = ~(sync_reg ^ key_level_select[i]);
        end
    endgenerate

endmodule

//--- design/kmi_top.v
// Key matrix line interrupt block with AXI4-Lite register slave
// Contract
// - Each line showing its programmed level sets its own flag bit.
// - A flag raises the keypad request only while its enable bit is one.
// - Flags stay set until software clears them, regardless of line level.
// - The flag register is read-only; writes leave flags unchanged.
// - Reading the flag register returns flags then clears all eight, except lines matching in that same cycle.
// - Enable zero keeps that line off the request and wake; its flag bit still sets.
// - Enable one lets that line flag contribute to the shared request.
// - After reset flags and enables read all zeros.
// - Level-select zero detects low, one detects high.
// - Eight lines are independent sources on one shared request.
// - Shared request is also gated by one global keypad enable.
// - Enabled line detection raises a wake signal for idle and power-down.
`timescale 1ns/1ps
`include "kmi_consts.vh"

module kmi_top (
    input  wire                  clock,
    input  wire                  reset_n,
    input  wire [`KMI_LINES-1:0] port_one,
    output reg                   keypad_irq,
    output reg                   keypad_wake,
    input  wire [11:0]           s_axi_awaddr,
    input  wire                  s_axi_awvalid,
    output reg                   s_axi_awready,
    input  wire [31:0]           s_axi_wdata,
    input  wire [3:0]            s_axi_wstrb,
    input  wire                  s_axi_wvalid,
    output reg                   s_axi_wready,
    output reg  [1:0]            s_axi_bresp,
    output reg                   s_axi_bvalid,
    input  wire                  s_axi_bready,
    input  wire [11:0]           s_axi_araddr,
    input  wire                  s_axi_arvalid,
    output reg                   s_axi_arready,
    output reg  [31:0]           s_axi_rdata,
    output reg  [1:0]            s_axi_rresp,
    output reg                   s_axi_rvalid,
    input  wire                  s_axi_rready
);

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    // Word selects use address bits 11:2; the byte offset is ignored
    localparam [11:0] ADDR_LEVEL  = `KMI_ADDR_LEVEL;
    localparam [11:0] ADDR_ENABLE = `KMI_ADDR_ENABLE;
    localparam [11:0] ADDR_FLAGS  = `KMI_ADDR_FLAGS;
    localparam [11:0] ADDR_CTRL   = `KMI_ADDR_CTRL;
    localparam [9:0]  SEL_LEVEL   = ADDR_LEVEL[11:2];
    localparam [9:0]  SEL_ENABLE  = ADDR_ENABLE[11:2];
    localparam [9:0]  SEL_FLAGS   = ADDR_FLAGS[11:2];
    localparam [9:0]  SEL_CTRL    = ADDR_CTRL[11:2];

    reg  [`KMI_LINES-1:0] key_line_enable_reg;
    reg  [`KMI_LINES-1:0] key_line_flags_reg;
    reg  [`KMI_LINES-1:0] key_level_select_reg;
    reg                   keypad_global_irq_enable_reg;
    reg  [11:0]           awaddr_reg;
    reg  [31:0]           wdata_reg;
    reg                   wstrb0_reg;
    reg                   aw_held_reg;
    reg                   w_held_reg;
    wire [`KMI_LINES-1:0] line_match;
    wire [`KMI_LINES-1:0] pending;
    wire                  do_write;
    wire                  do_read;
    wire                  flags_read;
    wire [`KMI_LINES-1:0] flags_next;
    wire [9:0]            aw_sel;
    wire [9:0]            ar_sel;

    // Lines reach the match logic two flops late
    kmi_line_sync u_sync (
        .clock            (clock),
        .reset_n          (reset_n),
        .port_one         (port_one),
        .key_level_select (key_level_select_reg),
        .line_match       (line_match)
    );

    // ------------------------------------------------------------
    // Flags and request
    // ------------------------------------------------------------
    assign do_read    = s_axi_arvalid & s_axi_arready;
    assign ar_sel     = s_axi_araddr[11:2];
    assign aw_sel     = awaddr_reg[11:2];
    // Sticky until read; a line going idle never clears its flag
    assign flags_read = do_read & (ar_sel == SEL_FLAGS);
    // A match in the clearing cycle is kept: set wins over the clear
    assign flags_next = (flags_read ? `KMI_RST_FLAGS
                                    : key_line_flags_reg)
                        | line_match;
    // Disabled lines still flag but never reach the request
    assign pending    = key_line_flags_reg & key_line_enable_reg;

    always @(posedge clock) begin
        if (!reset_n) begin
            key_line_flags_reg <= `KMI_RST_FLAGS;
            keypad_irq         <= 1'b0;
            keypad_wake        <= 1'b0;
        end else begin
            key_line_flags_reg <= flags_next;
            keypad_irq  <= (|pending) & keypad_global_irq_enable_reg;
            // Wake does not wait for the global enable
            keypad_wake <= |(line_match & key_line_enable_reg);
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    // Address and data are taken in either order and held; the
    // response waits until both are in
    // A new request may be taken while bvalid stands, but it is not
    // acted on before the old response has gone
    assign do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;

    always @(posedge clock) begin
        if (!reset_n) begin
            s_axi_awready                <= 1'b0;
            s_axi_wready                 <= 1'b0;
            s_axi_bvalid                 <= 1'b0;
            s_axi_bresp                  <= `KMI_RESP_OKAY;
            aw_held_reg                  <= 1'b0;
            w_held_reg                   <= 1'b0;
            awaddr_reg                   <= 12'h000;
            wdata_reg                    <= 32'h0000_0000;
            wstrb0_reg                   <= 1'b0;
            key_line_enable_reg          <= `KMI_RST_ENABLE;
            key_level_select_reg         <= `KMI_RST_LEVEL;
            keypad_global_irq_enable_reg <= `KMI_RST_CTRL;
        end else begin
            s_axi_awready <= ~aw_held_reg & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready  <= ~w_held_reg & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb0_reg <= s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `KMI_RESP_OKAY;
                // Only byte lane zero holds register bits
                case (aw_sel)
                    SEL_ENABLE: begin
                        if (wstrb0_reg)
                            key_line_enable_reg <= wdata_reg[7:0];
                    end
                    SEL_LEVEL: begin
                        if (wstrb0_reg)
                            key_level_select_reg <= wdata_reg[7:0];
                    end
                    SEL_CTRL: begin
                        // Gates the request only, never the flags
                        if (wstrb0_reg)
                            keypad_global_irq_enable_reg <=
                                wdata_reg[`KMI_CTRL_GLOBAL_EN];
                    end
                    SEL_FLAGS: begin
                        // Accepted and ignored
                        s_axi_bresp <= `KMI_RESP_OKAY;
                    end
                    default: begin
                        // Unmapped offsets answer an error, change nothing
                        s_axi_bresp <= `KMI_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    always @(posedge clock) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `KMI_RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (do_read) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `KMI_RESP_OKAY;
                // Flags are captured and cleared at one edge, so no
                // set is lost; upper data bits always read zero
                case (ar_sel)
                    SEL_ENABLE:
                        s_axi_rdata <= {24'h000000, key_line_enable_reg};
                    SEL_FLAGS:
                        s_axi_rdata <= {24'h000000, key_line_flags_reg};
                    SEL_LEVEL:
                        s_axi_rdata <= {24'h000000, key_level_select_reg};
                    SEL_CTRL:
                        s_axi_rdata <= {31'h00000000,
                                        keypad_global_irq_enable_reg};
                    default: begin
                        // Unmapped reads return zero with an error
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `KMI_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

//--- verification/kmi_keys.sv
// Key matrix model driving the eight port lines
`timescale 1ns/1ps
module kmi_keys (
    input  wire       clock,
    input  wire [7:0] press,
    output reg  [7:0] port_one
);
    // Pull-ups hold released lines high; a pressed key pulls low.
    // Lines move on the falling edge, unrelated to block sampling.
    always @(negedge clock)
        port_one <= ~press;
endmodule

//--- verification/kmi_monitor.sv
// Concurrent checks on the key line interrupt block ports
`timescale 1ns/1ps
`include "kmi_consts.vh"
module kmi_monitor (
    input wire        clock,
    input wire        reset_n,
    input wire        keypad_irq,
    input wire [11:0] s_axi_awaddr,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    sequence flag_wr;
        s_axi_awvalid && s_axi_awready && s_axi_wready
            && s_axi_awaddr == `KMI_ADDR_FLAGS;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    AST_RESET_QUIET:
        assert property ($rose(reset_n) |-> !keypad_irq && !s_axi_rvalid)
        else $error("output active after reset");
    // Bus activity may legally drop the request one edge later
    AST_IRQ_STICKY:
        assert property (keypad_irq && !s_axi_bvalid && !s_axi_rvalid
            |=> keypad_irq) else $error("request dropped");
    AST_FLAG_WR_OKAY:
        assert property (flag_wr |-> ##2 s_axi_bvalid
            && s_axi_bresp == `KMI_RESP_OKAY) else $error("flag write");
    AST_READ_ANSWER:
        assert property (rd_taken |=> s_axi_rvalid
            && s_axi_rdata[31:8] == 24'h0) else $error("read answer");
    AST_BVALID_DONE:
        assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    AST_RVALID_DONE:
        assert property (rd_taken ##1 s_axi_rvalid && s_axi_rready
            |=> !s_axi_rvalid) else $error("read data repeated");
    AST_AR_READY:
        assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
            |=> s_axi_arready) else $error("read address ignored");
    AST_AWREADY_PULSE:
        assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready held");
endmodule
bind kmi_top kmi_monitor kmi_monitor_inst (.*);

//--- verification/key_matrix_line_interrupts_tb.sv
// Self-checking bench for the key line interrupt block
`timescale 1ns/1ps
`include "kmi_consts.vh"
module key_matrix_line_interrupts_tb;
    reg         clock = 1'h0;
    reg         reset_n = 1'h0;
    reg  [7:0]  press = 8'h00;
    wire [7:0]  port_one;
    wire        keypad_irq, keypad_wake;
    reg  [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    reg  [31:0] s_axi_wdata = '0;
    reg  [3:0]  s_axi_wstrb = 4'hF;
    reg         s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
    reg         s_axi_arvalid = '0, s_axi_rready = '0;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire        s_axi_arready, s_axi_rvalid;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    integer     fails = 0, num_checks = 0, seed = 90, i;
    reg  [7:0]  e, p, m;
    reg  [33:0] rq[$];
    reg  [1:0]  bq[$];
    kmi_keys kmi_keys_inst (.clock(clock), .press(press), .port_one(port_one));
    kmi_top kmi_top_inst (.*);
    initial forever #5 clock = ~clock;
    // ----------------------------------------
    // Bus tasks and result checking
    // ----------------------------------------
    task chk(input string n, input [33:0] x, input [33:0] g);
        begin
            num_checks++;
            if (x !== g) begin
                fails++;
                $display("wrong value %s exp %h got %h", n, x, g);
            end
        end
    endtask
    task cyc(input integer n);
        begin
            repeat (n) @(posedge clock);
            #1;
        end
    endtask
    task wr(input [11:0] a, input [7:0] d, input [1:0] r);
        begin
            bq.push_back(r);
            s_axi_awaddr <= a;
            s_axi_wdata <= {24'h0, d};
            s_axi_awvalid <= 1'h1;
            s_axi_wvalid <= 1'h1;
            s_axi_bready <= 1'h1;
            do begin
                @(posedge clock);
                if (s_axi_awready) s_axi_awvalid <= 1'h0;
                if (s_axi_wready) s_axi_wvalid <= 1'h0;
            end while (!s_axi_bvalid);
        end
    endtask
    task rd(input [11:0] a, input [7:0] d, input [1:0] r);
        begin
            rq.push_back({r, 24'h0, d});
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'h1;
            s_axi_rready <= 1'h1;
            do begin
                @(posedge clock);
                if (s_axi_arready) s_axi_arvalid <= 1'h0;
            end while (!s_axi_rvalid);
        end
    endtask
    always @(posedge clock) begin
        if (s_axi_rvalid && s_axi_rready)
            chk("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
        if (s_axi_bvalid && s_axi_bready)
            chk("bresp", {32'h0, bq.pop_front()}, {32'h0, s_axi_bresp});
    end
    task wrap_up;
        begin
            $display("checks %0d mismatches %0d", num_checks, fails);
            if (fails == 0 && num_checks > 0) $display("bench passed");
            else $display("bench failed");
            $finish;
        end
    endtask
    initial begin
        #20000;
        fails++;
        wrap_up;
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        cyc(3);
        reset_n <= 1'h1;
        cyc(1);
        rd(`KMI_ADDR_ENABLE, 8'h00, 2'h0);
        rd(`KMI_ADDR_FLAGS, 8'h00, 2'h0);
        rd(12'h284, 8'h00, `KMI_RESP_SLVERR);
        wr(`KMI_ADDR_CTRL, 8'h01, 2'h0);
        for (i = 0; i < 6; i++) begin
            {m, p, e} = 24'($random(seed));
            wr(`KMI_ADDR_ENABLE, e, 2'h0);
            press <= p;
            cyc(6);
            chk("wake", |(p & e), keypad_wake);
            press <= 8'h00;
            cyc(6);
            chk("irq", |(p & e), keypad_irq);
            wr(`KMI_ADDR_CTRL, 8'h00, 2'h0);
            cyc(3);
            chk("gated irq", 1'h0, keypad_irq);
            wr(`KMI_ADDR_CTRL, 8'h01, 2'h0);
            wr(`KMI_ADDR_FLAGS, 8'h00, 2'h0);
            rd(`KMI_ADDR_FLAGS, p, 2'h0);
            rd(`KMI_ADDR_FLAGS, 8'h00, 2'h0);
            cyc(3);
            chk("irq cleared", 1'h0, keypad_irq);
        end
        // High-level detection: lines held low stop matching
        press <= 8'hFF;
        cyc(5);
        wr(`KMI_ADDR_LEVEL, 8'hFF, 2'h0);
        rd(`KMI_ADDR_FLAGS, 8'hFF, 2'h0);
        rd(`KMI_ADDR_FLAGS, 8'h00, 2'h0);
        m = 8'($random(seed));
        press <= ~m;
        cyc(6);
        rd(`KMI_ADDR_FLAGS, m, 2'h0);
        wrap_up;
    end
endmodule
